/* core/aio_pkg.sv */
// constants for the analog io parameter decoder and value encoder
// assumes a 200 MHz system clock and a byte-wide record write port
package aio_pkg;
  // ************************************************
  // record layout
  // ************************************************
  localparam int REC_LEN = 14;
  localparam logic [3:0] OFS_RESERVED_HEAD = 4'h0;
  localparam logic [3:0] OFS_INTEG_TIME = 4'h1;
  localparam logic [3:0] OFS_INPUT0 = 4'h2;
  localparam logic [3:0] OFS_INPUT3 = 4'h5;
  localparam logic [3:0] OFS_OUTPUT0 = 4'h6;
  localparam logic [3:0] OFS_OUTPUT1 = 4'h7;
  localparam logic [3:0] OFS_LAST = 4'hD;
  localparam int NUM_IN = 4;
  localparam int NUM_OUT = 2;
  // ************************************************
  // field codes
  // ************************************************
  localparam logic [1:0] ITIME_16MS6 = 2'h1;
  localparam logic [1:0] ITIME_20MS = 2'h2;
  localparam logic [3:0] TYPE_OFF = 4'h0;
  localparam logic [3:0] TYPE_VOLTAGE = 4'h1;
  localparam logic [3:0] TYPE_FOUR_WIRE_RESISTANCE = 4'h4;
  localparam logic [3:0] TYPE_FOUR_WIRE_THERMOMETER = 4'h8;
  localparam logic [3:0] RANGE_OFF_OR_CLIMATE = 4'h0;
  localparam logic [3:0] RANGE_0_10V = 4'h8;
  localparam logic [3:0] RANGE_10K = 4'h9;
  // ************************************************
  // reset values
  // ************************************************
  localparam logic [7:0] RST_INPUT_CFG = 8'h80;
  localparam logic [7:0] RST_OUTPUT_CFG = 8'h18;
  localparam logic [7:0] RST_ITIME = 8'hAA;
  // ************************************************
  // value codes
  // ************************************************
  localparam logic [15:0] CODE_OVERFLOW = 16'h7FFF;
  localparam logic [15:0] CODE_UNDERFLOW = 16'h8000;
  localparam logic [15:0] CODE_FULL_SCALE = 16'h6C00;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_OVERDRIVE_MAX = 16'h7EFF;
  // thermometer limits in hundredths of a degree
  localparam logic [15:0] TEMP_C_MAX = 16'h3C8C;
  localparam logic [15:0] TEMP_C_MIN = 16'hC75C;
  localparam logic [15:0] TEMP_F_MAX = 16'h797C;
  localparam logic [15:0] TEMP_F_MIN = 16'hA68C;
  localparam int SIGN_BIT = 15;
endpackage

/* core/aio_cfg_check.sv */
// checks one input channel configuration byte for support
// assumes combinational use inside the same clock domain
`timescale 1ns/100ps
module aio_cfg_check #(
  parameter int CHANNEL = 0
) (
  input wire logic [7:0] cfg_i,
  output logic bad_o,
  output logic off_o
);
  logic [3:0] typ;
  logic [3:0] rng;
  always_comb begin
    typ = cfg_i[7:4];
    rng = cfg_i[3:0];
    bad_o = 1'b1;
    off_o = 1'b0;
    case (typ)
      aio_pkg::TYPE_OFF: begin
        bad_o = 1'b0;
        off_o = 1'b1;
      end
      aio_pkg::TYPE_VOLTAGE: begin
        // voltage only on the second group
        bad_o = !(CHANNEL >= 2 && rng == aio_pkg::RANGE_0_10V);
      end
      aio_pkg::TYPE_FOUR_WIRE_RESISTANCE: begin
        bad_o = !(CHANNEL >= 2 && rng == aio_pkg::RANGE_10K);
      end
      aio_pkg::TYPE_FOUR_WIRE_THERMOMETER: begin
        bad_o = (rng != aio_pkg::RANGE_OFF_OR_CLIMATE);
      end
      default: begin
        bad_o = 1'b1;
      end
    endcase
  end
endmodule // aio_cfg_check

/* core/aio_param_scale.sv */
// parameter record decoder and analog value encoder
// assumes record bytes come from the bus logic on sys_clk_i, one per strobe,
// and raw converter results arrive on the same clock
`timescale 1ns/100ps

module aio_param_scale #(
  parameter int RAW_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic run_enter_i,
  input wire logic rec_wr_i,
  input wire logic [3:0] rec_idx_i,
  input wire logic [7:0] rec_data_i,
  input wire logic fahrenheit_i,
  input wire logic raw_valid_i,
  input wire logic [1:0] raw_ch_i,
  input wire logic signed [RAW_W-1:0] raw_i,
  input wire logic [0:0] out_ch_i,
  input wire logic out_wr_i,
  input wire logic [15:0] out_code_i,
  output logic [15:0] meas_o,
  output logic [1:0] meas_ch_o,
  output logic meas_valid_o,
  output logic [15:0] dac_code_o,
  output logic [0:0] dac_ch_o,
  output logic dac_valid_o,
  output logic [7:0] itime_o,
  output logic [31:0] in_cfg_o,
  output logic [15:0] out_cfg_o,
  output logic param_err_o,
  output logic rec_done_o
);
  // ************************************************
  // staging of the incoming record
  // ************************************************
  logic [7:0] stg_itime_q;
  logic [7:0] stg_in_q [aio_pkg::NUM_IN];
  logic [7:0] stg_out_q [aio_pkg::NUM_OUT];
  logic [3:0] cnt_q;
  logic full_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      full_q <= 1'b0;
    end else if (rec_wr_i) begin
      if (rec_idx_i == 4'h0) begin
        cnt_q <= 4'h1;
        full_q <= 1'b0;
      end else if (rec_idx_i == cnt_q && cnt_q == aio_pkg::OFS_LAST) begin
        cnt_q <= 4'h0;
        full_q <= 1'b1;
      end else if (rec_idx_i == cnt_q) begin
        cnt_q <= cnt_q + 4'h1;
      end else begin
        cnt_q <= 4'h0;
        full_q <= 1'b0;
      end
    end else if (run_enter_i) begin
      full_q <= 1'b0;
    end
  end

  // byte 0 and bytes past the outputs store nothing
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stg_itime_q <= aio_pkg::RST_ITIME;
      for (int i = 0; i < aio_pkg::NUM_IN; i++) begin
        stg_in_q[i] <= aio_pkg::RST_INPUT_CFG;
      end
      for (int i = 0; i < aio_pkg::NUM_OUT; i++) begin
        stg_out_q[i] <= aio_pkg::RST_OUTPUT_CFG;
      end
    end else if (rec_wr_i) begin
      if (rec_idx_i == aio_pkg::OFS_INTEG_TIME) begin
        stg_itime_q <= rec_data_i;
      end else if (rec_idx_i >= aio_pkg::OFS_INPUT0 && rec_idx_i <= aio_pkg::OFS_INPUT3) begin
        stg_in_q[2'(rec_idx_i - aio_pkg::OFS_INPUT0)] <= rec_data_i;
      end else if (rec_idx_i == aio_pkg::OFS_OUTPUT0) begin
        stg_out_q[0] <= rec_data_i;
      end else if (rec_idx_i == aio_pkg::OFS_OUTPUT1) begin
        stg_out_q[1] <= rec_data_i;
      end
      // other offsets carry no meaning
    end
  end

  // ************************************************
  // live configuration, swapped in whole at run entry after a complete record
  // ************************************************
  logic [7:0] itime_q;
  logic [7:0] in_q [aio_pkg::NUM_IN];
  logic [7:0] out_q [aio_pkg::NUM_OUT];
  logic [aio_pkg::NUM_IN-1:0] bad_w;
  logic [aio_pkg::NUM_IN-1:0] off_w;
  logic [aio_pkg::NUM_IN-1:0] bad_q;
  logic [aio_pkg::NUM_IN-1:0] off_q;
  logic out_bad_w;
  logic out_bad_q;
  logic [aio_pkg::NUM_OUT-1:0] out_off_q;
  logic apply;

  assign apply = run_enter_i && full_q;

  for (genvar g = 0; g < aio_pkg::NUM_IN; g++) begin : g_chk
    aio_cfg_check #(
      .CHANNEL(g)
    ) u_chk (
      .cfg_i(stg_in_q[g]),
      .bad_o(bad_w[g]),
      .off_o(off_w[g])
    );
  end

  // shared output group: both bytes must agree on type
  function automatic logic out_cfg_bad(input logic [7:0] a, input logic [7:0] b);
    logic ok_a;
    logic ok_b;
    ok_a = (a == {aio_pkg::TYPE_OFF, aio_pkg::RANGE_OFF_OR_CLIMATE})
        || (a == {aio_pkg::TYPE_VOLTAGE, aio_pkg::RANGE_0_10V});
    ok_b = (b == {aio_pkg::TYPE_OFF, aio_pkg::RANGE_OFF_OR_CLIMATE})
        || (b == {aio_pkg::TYPE_VOLTAGE, aio_pkg::RANGE_0_10V});
    return !(ok_a && ok_b && (a[7:4] == b[7:4]));
  endfunction

  assign out_bad_w = out_cfg_bad(stg_out_q[0], stg_out_q[1]);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      itime_q <= aio_pkg::RST_ITIME;
      for (int i = 0; i < aio_pkg::NUM_IN; i++) begin
        in_q[i] <= aio_pkg::RST_INPUT_CFG;
      end
      for (int i = 0; i < aio_pkg::NUM_OUT; i++) begin
        out_q[i] <= aio_pkg::RST_OUTPUT_CFG;
      end
      bad_q <= '0;
      off_q <= '0;
      out_bad_q <= 1'b0;
      out_off_q <= '0;
    end else if (apply) begin
      // all fields together, never a half record
      itime_q <= stg_itime_q;
      for (int i = 0; i < aio_pkg::NUM_IN; i++) begin
        in_q[i] <= stg_in_q[i];
      end
      for (int i = 0; i < aio_pkg::NUM_OUT; i++) begin
        out_q[i] <= stg_out_q[i];
        out_off_q[i] <= (stg_out_q[i][7:4] == aio_pkg::TYPE_OFF);
      end
      bad_q <= bad_w;
      off_q <= off_w;
      out_bad_q <= out_bad_w;
    end
  end

  // ************************************************
  // measurement encoding
  // ************************************************
  function automatic logic [15:0] clamp(input logic signed [31:0] v, input logic signed [31:0] hi,
                                        input logic signed [31:0] lo);
    if (v > hi) begin
      return aio_pkg::CODE_OVERFLOW;
    end else if (v < lo) begin
      return aio_pkg::CODE_UNDERFLOW;
    end
    return v[15:0];
  endfunction

  logic [15:0] enc;
  logic [7:0] sel_cfg;
  logic signed [31:0] rawx;
  always_comb begin
    sel_cfg = in_q[raw_ch_i];
    rawx = 32'(raw_i);
    enc = aio_pkg::CODE_OVERFLOW;
    if (bad_q[raw_ch_i] || off_q[raw_ch_i]) begin
      enc = aio_pkg::CODE_OVERFLOW;
    end else if (sel_cfg[7:4] == aio_pkg::TYPE_FOUR_WIRE_THERMOMETER) begin
      // raw already in hundredths of the chosen unit
      if (fahrenheit_i) begin
        enc = clamp(rawx, 32'(signed'(aio_pkg::TEMP_F_MAX)), 32'(signed'(aio_pkg::TEMP_F_MIN)));
      end else begin
        enc = clamp(rawx, 32'(signed'(aio_pkg::TEMP_C_MAX)), 32'(signed'(aio_pkg::TEMP_C_MIN)));
      end
    end else begin
      // voltage and resistance raw already scaled to full scale 27648
      enc = clamp(rawx, 32'(aio_pkg::CODE_OVERDRIVE_MAX), 32'(aio_pkg::CODE_ZERO));
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meas_o <= aio_pkg::CODE_OVERFLOW;
      meas_ch_o <= 2'h0;
      meas_valid_o <= 1'b0;
    end else begin
      meas_valid_o <= raw_valid_i;
      if (raw_valid_i) begin
        meas_o <= enc;
        meas_ch_o <= raw_ch_i;
      end
    end
  end

  // ************************************************
  // output code handling
  // ************************************************
  logic [15:0] dac_d;
  always_comb begin
    dac_d = out_code_i;
    // signed codes above full scale or below zero give zero volts
    if (out_code_i[aio_pkg::SIGN_BIT] || out_code_i > aio_pkg::CODE_FULL_SCALE) begin
      dac_d = aio_pkg::CODE_ZERO;
    end
    if (out_bad_q || out_off_q[out_ch_i]) begin
      dac_d = aio_pkg::CODE_ZERO;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dac_code_o <= aio_pkg::CODE_ZERO;
      dac_ch_o <= 1'b0;
      dac_valid_o <= 1'b0;
    end else begin
      dac_valid_o <= out_wr_i;
      if (out_wr_i) begin
        dac_code_o <= dac_d;
        dac_ch_o <= out_ch_i;
      end
    end
  end

  // ************************************************
  // status outputs
  // ************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      itime_o <= aio_pkg::RST_ITIME;
      in_cfg_o <= {4{aio_pkg::RST_INPUT_CFG}};
      out_cfg_o <= {2{aio_pkg::RST_OUTPUT_CFG}};
      param_err_o <= 1'b0;
      rec_done_o <= 1'b0;
    end else begin
      itime_o <= itime_q;
      in_cfg_o <= {in_q[3], in_q[2], in_q[1], in_q[0]};
      out_cfg_o <= {out_q[1], out_q[0]};
      param_err_o <= (|bad_q) || out_bad_q;
      rec_done_o <= full_q;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  sequence s_apply;
    run_enter_i && full_q;
  endsequence

  a_bad_reports_overflow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    raw_valid_i && (bad_q[raw_ch_i] || off_q[raw_ch_i]) |=> meas_o == aio_pkg::CODE_OVERFLOW)
    else $error("bad channel not reporting overflow");
  a_apply_itime: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_apply ##1 1'b1 |=> itime_o == $past(stg_itime_q, 2))
    else $error("integration time not applied");
  a_hold_cfg: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !apply |=> $stable(itime_q))
    else $error("config changed without run entry");
  a_dac_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    out_wr_i && out_code_i > aio_pkg::CODE_FULL_SCALE |=> dac_code_o == aio_pkg::CODE_ZERO)
    else $error("out of range output not zero");
  a_meas_valid: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    raw_valid_i |=> meas_valid_o && meas_ch_o == $past(raw_ch_i))
    else $error("measurement not returned");
  a_temp_clip: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    raw_valid_i && !bad_q[raw_ch_i] && !off_q[raw_ch_i] && in_q[raw_ch_i][7:4] == aio_pkg::TYPE_FOUR_WIRE_THERMOMETER
    && !fahrenheit_i && raw_i > $signed(aio_pkg::TEMP_C_MAX) |=> meas_o == aio_pkg::CODE_OVERFLOW)
    else $error("thermometer overflow missing");
  a_record_len: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rec_wr_i && rec_idx_i == aio_pkg::OFS_LAST && cnt_q == aio_pkg::OFS_LAST |=> full_q ##1 rec_done_o)
    else $error("fourteen byte record not completed");
  a_err_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s_apply and (|bad_w)) |=> ##1 param_err_o)
    else $error("parameter error not flagged");

  // steps of a record transfer
  sequence s_last_byte;
    rec_wr_i && rec_idx_i == aio_pkg::OFS_LAST && cnt_q == aio_pkg::OFS_LAST;
  endsequence
  sequence s_stray_byte;
    rec_wr_i && rec_idx_i != 4'h0 && rec_idx_i != cnt_q;
  endsequence
  a_stray_restart: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_stray_byte |=> cnt_q == 4'h0 && !full_q)
    else $error("out of order byte kept record progress");
  a_last_sets_full: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_last_byte |=> full_q && cnt_q == 4'h0)
    else $error("last record byte did not complete record");
  a_run_clears_done: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    run_enter_i && !rec_wr_i |=> !full_q ##1 !rec_done_o)
    else $error("record still marked complete after run entry");
  a_hold_inputs: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !apply |=> $stable({in_q[3], in_q[2], in_q[1], in_q[0]}) && $stable({out_q[1], out_q[0]}))
    else $error("channel config changed outside a complete record");
  a_apply_inputs: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_apply ##1 1'b1 |=> in_cfg_o == $past({stg_in_q[3], stg_in_q[2], stg_in_q[1], stg_in_q[0]}, 2))
    else $error("input configuration not applied");
  a_dac_pass: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    out_wr_i && !out_bad_q && !out_off_q[out_ch_i] && !out_code_i[aio_pkg::SIGN_BIT]
    && out_code_i <= aio_pkg::CODE_FULL_SCALE |=> dac_code_o == $past(out_code_i))
    else $error("in range output code altered");
  a_dac_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    out_wr_i && (out_bad_q || out_off_q[out_ch_i]) |=> dac_code_o == aio_pkg::CODE_ZERO)
    else $error("deactivated or bad output not at zero");
  a_first_group: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    stg_in_q[0][7:4] != aio_pkg::TYPE_FOUR_WIRE_THERMOMETER
    && stg_in_q[0][7:4] != aio_pkg::TYPE_OFF |-> bad_w[0])
    else $error("first group accepted a non thermometer type");
  a_under_clip: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    raw_valid_i && !bad_q[raw_ch_i] && !off_q[raw_ch_i] && raw_i < 0
    && in_q[raw_ch_i][7:4] != aio_pkg::TYPE_FOUR_WIRE_THERMOMETER |=> meas_o == aio_pkg::CODE_UNDERFLOW)
    else $error("negative linear value not reported as underflow");
endmodule // aio_param_scale

/* testbench/aio_ctrl_model.sv */
// controller-side model: writes the parameter record and enters run
// assumes the record port of aio_param_scale on the same clock
`timescale 1ns/100ps
module aio_ctrl_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic send_i,
  input wire logic [111:0] rec_i,
  input wire logic [3:0] gap_i,
  input wire logic [3:0] skip_i,
  output logic rec_wr_o,
  output logic [3:0] rec_idx_o,
  output logic [7:0] rec_data_o,
  output logic run_enter_o,
  output logic busy_o
);
  // ************************************************
  // record sender
  // ************************************************
  logic [4:0] pos_q;
  logic [3:0] wait_q;
  always_ff @(posedge sys_clk_i) begin
    rec_wr_o <= 1'b0;
    run_enter_o <= 1'b0;
    // released lines toggle so that stale data is never mistaken for a byte
    rec_idx_o <= ~rec_idx_o;
    rec_data_o <= ~rec_data_o;
    if (rst_i) begin
      busy_o <= 1'b0;
      pos_q <= 5'h00;
      wait_q <= 4'h0;
      rec_idx_o <= 4'h0;
      rec_data_o <= 8'h00;
    end else if (send_i && !busy_o) begin
      busy_o <= 1'b1;
      pos_q <= 5'h00;
      wait_q <= 4'h0;
    end else if (busy_o) begin
      if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (pos_q == 5'h10) begin
        run_enter_o <= 1'b1;
        busy_o <= 1'b0;
      end else if (pos_q >= 5'h0E) begin
        pos_q <= pos_q + 5'h01;
      end else begin
        // skip only when commanded, to break the byte order on purpose
        if (skip_i == 4'h0 || pos_q[3:0] != skip_i) begin
          rec_wr_o <= 1'b1;
          rec_idx_o <= pos_q[3:0];
          rec_data_o <= rec_i[8*pos_q +: 8];
        end
        pos_q <= pos_q + 5'h01;
        wait_q <= gap_i;
      end
    end
  end
endmodule // aio_ctrl_model

/* testbench/analog_io_param_and_scaling_test.sv */
// self-checking bench for aio_param_scale
// assumes aio_ctrl_model drives the record port
`timescale 1ns/100ps
module analog_io_param_and_scaling_test;
  // ************************************************
  // signals and instances
  // ************************************************
  logic clk, rst, fahr, rv, ow, send, busy, wr, run, mv, dv, perr, rdone;
  logic [1:0] rch, mch;
  logic [0:0] och, dch;
  logic [15:0] raw, ocode, meas_q, dac_q, outcfg;
  logic [3:0] idx, gap, skip;
  logic [7:0] dat, itime;
  logic [31:0] incfg;
  logic [111:0] rec;
  int miscompares = 0;
  int n_checks = 0;
  logic [15:0] traw [9] = '{16'h32C8, 16'h3C8C, 16'h3C8D, 16'hC75C, 16'hC75B, 16'h797C, 16'h797D, 16'hA68C, 16'hA68B};
  logic [15:0] texp [9] = '{16'h32C8, 16'h3C8C, 16'h7FFF, 16'hC75C, 16'h8000, 16'h797C, 16'h7FFF, 16'hA68C, 16'h8000};
  aio_ctrl_model i_ctrl (.sys_clk_i(clk), .rst_i(rst), .send_i(send), .rec_i(rec), .gap_i(gap), .skip_i(skip),
    .rec_wr_o(wr), .rec_idx_o(idx), .rec_data_o(dat), .run_enter_o(run), .busy_o(busy));
  aio_param_scale i_dut (.sys_clk_i(clk), .rst_i(rst), .run_enter_i(run), .rec_wr_i(wr), .rec_idx_i(idx),
    .rec_data_i(dat), .fahrenheit_i(fahr), .raw_valid_i(rv), .raw_ch_i(rch), .raw_i(raw), .out_ch_i(och),
    .out_wr_i(ow), .out_code_i(ocode), .meas_o(meas_q), .meas_ch_o(mch), .meas_valid_o(mv), .dac_code_o(dac_q),
    .dac_ch_o(dch), .dac_valid_o(dv), .itime_o(itime), .in_cfg_o(incfg), .out_cfg_o(outcfg),
    .param_err_o(perr), .rec_done_o(rdone));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ************************************************
  // tasks
  // ************************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic meas(input logic [1:0] ch, input logic [15:0] r, input logic [15:0] e);
    @(posedge clk);
    rv <= 1'b1;
    rch <= ch;
    raw <= r;
    @(posedge clk);
    rv <= 1'b0;
    #1;
    check({mv, mch, meas_q}, {1'b1, ch, e});
  endtask
  task automatic dac(input logic [0:0] ch, input logic [15:0] c, input logic [15:0] e);
    @(posedge clk);
    ow <= 1'b1;
    och <= ch;
    ocode <= c;
    @(posedge clk);
    ow <= 1'b0;
    #1;
    check({dv, dch, dac_q}, {1'b1, ch, e});
  endtask
  // bounded wait: the model takes no input from the record port and stays busy at most 227 cycles, at gap 15
  task automatic send_rec(input logic [111:0] r, input logic [3:0] g, input logic [3:0] s);
    int n;
    logic seen;
    @(posedge clk);
    rec <= r;
    gap <= g;
    skip <= s;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    n = 0;
    seen = 1'b0;
    @(posedge clk);
    while (busy === 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
      seen = seen | (rdone === 1'b1);
    end
    if (n >= 300) begin
      miscompares++;
      stop_test();
    end
    repeat (4) @(posedge clk);
    #1;
    check(seen, s == 4'h0);
  endtask
  function automatic logic [111:0] mk(input logic [7:0] it, i0, i1, i2, i3, o0, o1);
    return {48'hA5C35A3CF00F, o1, o0, i3, i2, i1, i0, it, 8'hE7};
  endfunction
  // ************************************************
  // sequence
  // ************************************************
  initial begin
    rst = 1'b1;
    fahr = 1'b0;
    rv = 1'b0;
    ow = 1'b0;
    send = 1'b0;
    rch = 2'h0;
    och = 1'b0;
    raw = 16'h0000;
    ocode = 16'h0000;
    gap = 4'h0;
    skip = 4'h0;
    rec = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(incfg, 32'h80808080);
    check({outcfg, itime, perr, rdone}, {16'h1818, 8'hAA, 2'b00});
    for (int i = 0; i < 9; i++) begin
      fahr <= (i > 4);
      meas(i[1:0], traw[i], texp[i]);
    end
    fahr <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      dac(i[0], 16'h6C00, 16'h6C00);
      dac(i[0], 16'h6C01, 16'h0000);
      dac(i[0], 16'h8000, 16'h0000);
    end
    send_rec(mk(8'h56, 8'h80, 8'h80, 8'h18, 8'h49, 8'h18, 8'h18), 4'h0, 4'h0);
    check({itime, incfg, outcfg, perr}, {8'h56, 32'h49188080, 16'h1818, 1'b0});
    meas(2'h2, 16'h6C00, 16'h6C00);
    meas(2'h2, 16'h7EFF, 16'h7EFF);
    meas(2'h2, 16'h7F00, 16'h7FFF);
    meas(2'h2, 16'hFFFF, 16'h8000);
    meas(2'h3, 16'h5100, 16'h5100);
    meas(2'h0, 16'hD120, 16'hD120);
    send_rec(mk(8'hAA, 8'h18, 8'h00, 8'h18, 8'h49, 8'h00, 8'h00), 4'h3, 4'h0);
    check({itime, outcfg, perr}, {8'hAA, 16'h0000, 1'b1});
    meas(2'h0, 16'h0100, 16'h7FFF);
    meas(2'h1, 16'h0100, 16'h7FFF);
    dac(1'b0, 16'h1000, 16'h0000);
    send_rec(mk(8'h56, 8'h80, 8'h80, 8'h28, 8'h49, 8'h28, 8'h28), 4'h0, 4'h0);
    check({outcfg, perr}, {16'h2828, 1'b1});
    meas(2'h2, 16'h6C00, 16'h7FFF);
    dac(1'b1, 16'h6C00, 16'h0000);
    send_rec(mk(8'h56, 8'h80, 8'h80, 8'h18, 8'h49, 8'h18, 8'h18), 4'h1, 4'h6);
    check({incfg, rdone}, {32'h49288080, 1'b0});
    send_rec(mk(8'h56, 8'h80, 8'h80, 8'h18, 8'h49, 8'h18, 8'h18), 4'h0, 4'h0);
    check(perr, 1'b0);
    meas(2'h2, 16'h6C00, 16'h6C00);
    stop_test();
  end
endmodule // analog_io_param_and_scaling_test
